/* File: design/apc_clkgen.v */
// Bit and word clock generator for one serial audio port.
// Assumes tick is a one-cycle enable at twice the bit clock rate.
`timescale 1ns/10ps
`include "apc_consts.vh"
module apc_clkgen (
  input  wire clk,
  input  wire rst_n,
  input  wire tick,
  input  wire en,
  output reg  bclk_q,
  output reg  wclk_q
);
  reg [5:0] bit_cnt_q;

  // Word clock flips after a full word of bit clock periods
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bclk_q    <= 1'b0;
      wclk_q    <= 1'b0;
      bit_cnt_q <= 6'h00;
    end else if (!en) begin
      bclk_q    <= 1'b0;
      wclk_q    <= 1'b0;
      bit_cnt_q <= 6'h00;
    end else if (tick) begin
      bclk_q <= ~bclk_q;
      if (bclk_q) begin
        if (bit_cnt_q == `APC_BITS_PER_WORD - 6'h01) begin
          bit_cnt_q <= 6'h00;
          wclk_q    <= ~wclk_q;
        end else begin
          bit_cnt_q <= bit_cnt_q + 6'h01;
        end
      end
    end
  end
endmodule

/* File: design/apc_consts.vh */
// Constants for the audio pin controller: register map, fields, pin slots.
// Assumes a 32-bit APB with byte addresses in paddr[7:0].
`ifndef APC_CONSTS_VH
`define APC_CONSTS_VH

// Register byte offsets
`define APC_REG_CTRL      8'h00
`define APC_REG_DIV       8'h04
`define APC_REG_GPIO_OUT  8'h08
`define APC_REG_GPIO_EN   8'h0c
`define APC_REG_GPIO_IN   8'h10
`define APC_REG_SUBCODE   8'h14
`define APC_REG_STATUS    8'h18

// Control register fields
`define APC_CTRL_BDIR     2:0
`define APC_CTRL_WDIR     5:3
`define APC_CTRL_EXTCLK   6
`define APC_CTRL_SEL      8:7
`define APC_CTRL_FN       15:9
`define APC_CTRL_W        16
`define APC_CTRL_RST      16'h0000
`define APC_DIV_RST       8'h03

// Pin function group bits inside the FN field (1 = general purpose)
`define APC_FN_SIN        3
`define APC_FN_SOUT       4
`define APC_FN_SPDIF      5
`define APC_FN_SUB        6

// Subcode write fields
`define APC_SUB_DATA      7:0
`define APC_SUB_SYNC      8
`define APC_SUB_BITS      4'h8

// Driven pin slots
`define APC_NPIN          12
`define APC_PIN_WCLK      3
`define APC_PIN_SOUT1     6
`define APC_PIN_SOUT2     7
`define APC_PIN_SPC       8
`define APC_PIN_SPP       9
`define APC_PIN_SYNC      10
`define APC_PIN_SDAT      11
`define APC_PIN_OE_N_RST  12'h03f

// Sampled input slots
`define APC_NIN           15
`define APC_IN_BCLK       0
`define APC_IN_WCLK       3
`define APC_IN_SIN1       6
`define APC_IN_SIN3       7
`define APC_IN_EF         8
`define APC_IN_CD_CONTROL_FLAG_IN       9
`define APC_IN_SPDIF      10
`define APC_IN_RCK        14

// Serial clock framing
`define APC_BITS_PER_WORD 6'h20
`endif

/* File: design/apc_pins.v */
// Audio pin controller: serial audio, digital audio and subcode pins.
// Assumes an APB master on pclk; all pins are asynchronous to pclk.
`timescale 1ns/10ps
`include "apc_consts.vh"
module apc_pins (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        bit_clock_port1_i,
  output wire        bit_clock_port1_o,
  output wire        bit_clock_port1_oe_n,
  input  wire        bit_clock_port2_i,
  output wire        bit_clock_port2_o,
  output wire        bit_clock_port2_oe_n,
  input  wire        bit_clock_port3_i,
  output wire        bit_clock_port3_o,
  output wire        bit_clock_port3_oe_n,
  input  wire        word_clock_port1_i,
  output wire        word_clock_port1_o,
  output wire        word_clock_port1_oe_n,
  input  wire        word_clock_port2_i,
  output wire        word_clock_port2_o,
  output wire        word_clock_port2_oe_n,
  input  wire        word_clock_port3_i,
  output wire        word_clock_port3_o,
  output wire        word_clock_port3_oe_n,
  input  wire        serial_in_port1,
  input  wire        serial_in_port3,
  output wire        serial_out_port1,
  output wire        serial_out_port1_oe_n,
  output wire        serial_out_port2,
  output wire        serial_out_port2_oe_n,
  input  wire        cd_error_flag_in,
  input  wire        cd_control_flag_in,
  input  wire        spdif_in_a,
  input  wire        spdif_in_b,
  input  wire        spdif_in_c,
  input  wire        spdif_in_d,
  output wire        spdif_out_consumer,
  output wire        spdif_out_consumer_oe_n,
  output wire        spdif_out_professional,
  output wire        spdif_out_professional_oe_n,
  input  wire        subcode_clk_in,
  output wire        subcode_sync_out,
  output wire        subcode_sync_out_oe_n,
  output wire        subcode_data_out,
  output wire        subcode_data_out_oe_n,
  input  wire        tx_data_port1,
  input  wire        tx_data_port2,
  input  wire        tx_spdif_consumer,
  input  wire        tx_spdif_professional,
  output wire [2:0]  port_bit_clk,
  output wire [2:0]  port_word_clk,
  output wire        rx_data_port1,
  output wire        rx_data_port3,
  output wire        rx_error_flag_port1,
  output wire        rx_control_flag_port1,
  output wire        spdif_rx_data
);
  reg  [`APC_CTRL_W-1:0] ctrl_q;
  reg  [7:0]             div_q;
  reg  [7:0]             div_cnt_q;
  reg  [`APC_NPIN-1:0]   gpio_out_q;
  reg  [`APC_NPIN-1:0]   gpio_en_q;
  reg  [8:0]             sc_hold_q;
  reg                    sc_pend_q;
  reg  [7:0]             sc_shift_q;
  reg  [3:0]             sc_cnt_q;
  reg                    sc_sync_q;
  reg  [31:0]            prdata_q;
  reg                    pslverr_q;
  reg  [`APC_NPIN-1:0]   pin_o_q;
  reg  [`APC_NPIN-1:0]   pin_oe_n_q;
  reg  [`APC_NPIN-1:0]   pin_o_d;
  reg  [`APC_NPIN-1:0]   pin_oe_n_d;
  reg  [`APC_NPIN-1:0]   aud_o;
  reg  [`APC_NPIN-1:0]   aud_oe_n;
  reg  [`APC_NPIN-1:0]   gfn;
  reg  [2:0]             bclk_q;
  reg  [2:0]             wclk_q;
  reg                    rx1_q;
  reg                    rx3_q;
  reg                    ef_q;
  reg                    cd_control_flag_in_q;
  reg                    spdif_rx_q;
  reg                    rck_prev_q;
  reg                    w3_prev_q;
  reg  [31:0]            rd_d;
  reg                    err_d;
  wire [`APC_NIN-1:0]    in_raw;
  wire [`APC_NIN-1:0]    in_s;
  wire [2:0]             gen_b;
  wire [2:0]             gen_w;
  wire [2:0]             gen_en;
  wire [6:0]             fn;
  wire [2:0]             bdir;
  wire [2:0]             wdir;
  wire                   ext_clk;
  wire                   int_tick;
  wire                   tick;
  wire                   rck_fall;
  wire                   w3_rise;
  wire                   wr_en;
  wire                   sc_wr;
  wire                   sub_on;
  integer                i;
  integer                j;

  assign fn      = ctrl_q[`APC_CTRL_FN];
  assign bdir    = ctrl_q[`APC_CTRL_BDIR];
  assign wdir    = ctrl_q[`APC_CTRL_WDIR];
  assign ext_clk = ctrl_q[`APC_CTRL_EXTCLK];
  assign sub_on  = ~fn[`APC_FN_SUB];

  // All input pins sampled here, so gpio reads see them whatever their use
  assign in_raw = {subcode_clk_in,
                   spdif_in_d, spdif_in_c, spdif_in_b, spdif_in_a,
                   cd_control_flag_in, cd_error_flag_in,
                   serial_in_port3, serial_in_port1,
                   word_clock_port3_i, word_clock_port2_i,
                   word_clock_port1_i,
                   bit_clock_port3_i, bit_clock_port2_i,
                   bit_clock_port1_i};

  apc_sync3 #(
    .WIDTH (`APC_NIN)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (in_raw),
    .dout  (in_s)
  );

  // APB slave, zero wait states
  assign wr_en   = psel & penable & pwrite;
  assign sc_wr   = wr_en & (paddr == `APC_REG_SUBCODE);
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  always @* begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    case (paddr)
      `APC_REG_CTRL:     rd_d[`APC_CTRL_W-1:0] = ctrl_q;
      `APC_REG_DIV:      rd_d[7:0] = div_q;
      `APC_REG_GPIO_OUT: rd_d[`APC_NPIN-1:0] = gpio_out_q;
      `APC_REG_GPIO_EN:  rd_d[`APC_NPIN-1:0] = gpio_en_q;
      `APC_REG_GPIO_IN:  rd_d[`APC_NIN-1:0] = in_s;
      `APC_REG_SUBCODE:  rd_d[8:0] = sc_hold_q;
      `APC_REG_STATUS:   rd_d[3:0] = {cd_control_flag_in_q, ef_q,
                                      (sc_cnt_q != 4'h0), sc_pend_q};
      default:           err_d = 1'b1;
    endcase
  end

  // Read data captured in the setup cycle, stable through access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel & ~penable) begin
      prdata_q  <= pwrite ? 32'h0000_0000 : rd_d;
      pslverr_q <= err_d;
    end
  end

  // Configuration registers; reset leaves every pin in its audio role
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= `APC_CTRL_RST;
      div_q      <= `APC_DIV_RST;
      gpio_out_q <= {`APC_NPIN{1'b0}};
      gpio_en_q  <= {`APC_NPIN{1'b0}};
    end else if (wr_en) begin
      case (paddr)
        `APC_REG_CTRL:     ctrl_q <= pwdata[`APC_CTRL_W-1:0];
        `APC_REG_DIV:      div_q <= pwdata[7:0];
        `APC_REG_GPIO_OUT: gpio_out_q <= pwdata[`APC_NPIN-1:0];
        `APC_REG_GPIO_EN:  gpio_en_q <= pwdata[`APC_NPIN-1:0];
        default:           ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Audio clock source: internal divider or port 3 word pin as master
  assign int_tick = (div_cnt_q == div_q);
  assign w3_rise  = in_s[`APC_IN_WCLK + 2] & ~w3_prev_q;
  assign tick     = ext_clk ? w3_rise : int_tick;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q  <= 8'h00;
      w3_prev_q  <= 1'b0;
      rck_prev_q <= 1'b0;
    end else begin
      div_cnt_q  <= int_tick ? 8'h00 : div_cnt_q + 8'h01;
      w3_prev_q  <= in_s[`APC_IN_WCLK + 2];
      rck_prev_q <= in_s[`APC_IN_RCK];
    end
  end

  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_port
      // Port 3 still makes its own word clock from its own master input; only its word pin drive is cut
      assign gen_en[p] = (bdir[p] | wdir[p]) & ~fn[p];
      apc_clkgen u_gen (
        .clk    (pclk),
        .rst_n  (presetn),
        .tick   (tick),
        .en     (gen_en[p]),
        .bclk_q (gen_b[p]),
        .wclk_q (gen_w[p])
      );
    end
  endgenerate

  // Audio-role drive and gpio overrides for every driven pin
  always @* begin
    for (i = 0; i < 3; i = i + 1) begin
      aud_o[i]                 = gen_b[i];
      aud_oe_n[i]              = ~bdir[i];
      aud_o[`APC_PIN_WCLK + i] = gen_w[i];
      aud_oe_n[`APC_PIN_WCLK + i] = ~wdir[i];
      gfn[i]                   = fn[i];
      gfn[`APC_PIN_WCLK + i]   = fn[i];
    end
    if (ext_clk) begin
      aud_oe_n[`APC_PIN_WCLK + 2] = 1'b1;
    end
    aud_o[`APC_PIN_SOUT1]    = tx_data_port1;
    aud_o[`APC_PIN_SOUT2]    = tx_data_port2;
    aud_o[`APC_PIN_SPC]      = tx_spdif_consumer;
    aud_o[`APC_PIN_SPP]      = tx_spdif_professional;
    aud_o[`APC_PIN_SYNC]     = sc_sync_q;
    aud_o[`APC_PIN_SDAT]     = sc_shift_q[7] & (sc_cnt_q != 4'h0);
    aud_oe_n[`APC_PIN_SOUT1] = 1'b0;
    aud_oe_n[`APC_PIN_SOUT2] = 1'b0;
    aud_oe_n[`APC_PIN_SPC]   = 1'b0;
    aud_oe_n[`APC_PIN_SPP]   = 1'b0;
    aud_oe_n[`APC_PIN_SYNC]  = 1'b0;
    aud_oe_n[`APC_PIN_SDAT]  = 1'b0;
    gfn[`APC_PIN_SOUT1]      = fn[`APC_FN_SOUT];
    gfn[`APC_PIN_SOUT2]      = fn[`APC_FN_SOUT];
    gfn[`APC_PIN_SPC]        = fn[`APC_FN_SPDIF];
    gfn[`APC_PIN_SPP]        = fn[`APC_FN_SPDIF];
    gfn[`APC_PIN_SYNC]       = fn[`APC_FN_SUB];
    gfn[`APC_PIN_SDAT]       = fn[`APC_FN_SUB];
    pin_o_d    = (gfn & gpio_out_q) | (~gfn & aud_o);
    pin_oe_n_d = (gfn & ~gpio_en_q) | (~gfn & aud_oe_n);
  end

  // Pins registered so they never glitch while the mux settles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_o_q    <= {`APC_NPIN{1'b0}};
      pin_oe_n_q <= `APC_PIN_OE_N_RST;
    end else begin
      pin_o_q    <= pin_o_d;
      pin_oe_n_q <= pin_oe_n_d;
    end
  end

  assign bit_clock_port1_o           = pin_o_q[0];
  assign bit_clock_port1_oe_n        = pin_oe_n_q[0];
  assign bit_clock_port2_o           = pin_o_q[1];
  assign bit_clock_port2_oe_n        = pin_oe_n_q[1];
  assign bit_clock_port3_o           = pin_o_q[2];
  assign bit_clock_port3_oe_n        = pin_oe_n_q[2];
  assign word_clock_port1_o          = pin_o_q[`APC_PIN_WCLK];
  assign word_clock_port1_oe_n       = pin_oe_n_q[`APC_PIN_WCLK];
  assign word_clock_port2_o          = pin_o_q[`APC_PIN_WCLK + 1];
  assign word_clock_port2_oe_n       = pin_oe_n_q[`APC_PIN_WCLK + 1];
  assign word_clock_port3_o          = pin_o_q[`APC_PIN_WCLK + 2];
  assign word_clock_port3_oe_n       = pin_oe_n_q[`APC_PIN_WCLK + 2];
  assign serial_out_port1            = pin_o_q[`APC_PIN_SOUT1];
  assign serial_out_port1_oe_n       = pin_oe_n_q[`APC_PIN_SOUT1];
  assign serial_out_port2            = pin_o_q[`APC_PIN_SOUT2];
  assign serial_out_port2_oe_n       = pin_oe_n_q[`APC_PIN_SOUT2];
  assign spdif_out_consumer          = pin_o_q[`APC_PIN_SPC];
  assign spdif_out_consumer_oe_n     = pin_oe_n_q[`APC_PIN_SPC];
  assign spdif_out_professional      = pin_o_q[`APC_PIN_SPP];
  assign spdif_out_professional_oe_n = pin_oe_n_q[`APC_PIN_SPP];
  assign subcode_sync_out            = pin_o_q[`APC_PIN_SYNC];
  assign subcode_sync_out_oe_n       = pin_oe_n_q[`APC_PIN_SYNC];
  assign subcode_data_out            = pin_o_q[`APC_PIN_SDAT];
  assign subcode_data_out_oe_n       = pin_oe_n_q[`APC_PIN_SDAT];

  // Core-side view: clocks, receive data and CD flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_q     <= 3'h0;
      wclk_q     <= 3'h0;
      rx1_q      <= 1'b0;
      rx3_q      <= 1'b0;
      ef_q       <= 1'b0;
      cd_control_flag_in_q     <= 1'b0;
      spdif_rx_q <= 1'b0;
    end else begin
      for (j = 0; j < 3; j = j + 1) begin
        bclk_q[j] <= bdir[j] ? gen_b[j] : in_s[`APC_IN_BCLK + j];
        wclk_q[j] <= wdir[j] ? gen_w[j] : in_s[`APC_IN_WCLK + j];
      end
      // Gpio-mode data pins give the ports silence, not stray levels
      rx1_q  <= in_s[`APC_IN_SIN1] & ~fn[`APC_FN_SIN];
      rx3_q  <= in_s[`APC_IN_SIN3] & ~fn[`APC_FN_SIN];
      ef_q   <= in_s[`APC_IN_EF] & ~fn[`APC_FN_SIN];
      cd_control_flag_in_q <= in_s[`APC_IN_CD_CONTROL_FLAG_IN] & ~fn[`APC_FN_SIN];
      spdif_rx_q <= in_s[`APC_IN_SPDIF +
                         {1'b0, ctrl_q[`APC_CTRL_SEL]}];
    end
  end

  assign port_bit_clk          = bclk_q;
  assign port_word_clk         = wclk_q;
  assign rx_data_port1         = rx1_q;
  assign rx_data_port3         = rx3_q;
  assign rx_error_flag_port1   = ef_q;
  assign rx_control_flag_port1 = cd_control_flag_in_q;
  assign spdif_rx_data         = spdif_rx_q;

  // Subcode sender; encoder clock edges come only through the synchroniser
  assign rck_fall = sub_on & rck_prev_q & ~in_s[`APC_IN_RCK];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_hold_q  <= 9'h000;
      sc_pend_q  <= 1'b0;
      sc_shift_q <= 8'h00;
      sc_cnt_q   <= 4'h0;
      sc_sync_q  <= 1'b0;
    end else begin
      if (rck_fall) begin
        if ((sc_cnt_q <= 4'h1) && sc_pend_q) begin
          // Back-to-back bytes leave no gap on the data line
          sc_shift_q <= sc_hold_q[`APC_SUB_DATA];
          sc_sync_q  <= sc_hold_q[`APC_SUB_SYNC];
          sc_cnt_q   <= `APC_SUB_BITS;
          sc_pend_q  <= 1'b0;
        end else if (sc_cnt_q != 4'h0) begin
          sc_shift_q <= {sc_shift_q[6:0], 1'b0};
          sc_cnt_q   <= sc_cnt_q - 4'h1;
          if (sc_cnt_q == 4'h1) begin
            sc_sync_q <= 1'b0;
          end
        end
      end
      // A new byte written as the old one is taken still counts
      if (sc_wr) begin
        sc_hold_q <= pwdata[8:0];
        sc_pend_q <= 1'b1;
      end
    end
  end
endmodule

/* File: design/apc_sync3.v */
// Three-stage input synchroniser with agreement filter.
// Assumes inputs asynchronous to clk; output changes once stages 2 and 3 agree.
`timescale 1ns/10ps
module apc_sync3 #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;

  // First stage feeds only the second one
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= {WIDTH{1'b0}};
      s2_q <= {WIDTH{1'b0}};
      s3_q <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      dout <= (s3_q & ~(s2_q ^ s3_q)) | (dout & (s2_q ^ s3_q));
    end
  end
endmodule

/* File: sim/apc_encoder_model.sv */
// Channel encoder stand-in: drives the subcode clock, reads sync and data.
// Assumes run frames the clock; the clock idles high between frames.
`timescale 1ns/10ps
module apc_encoder_model (
  input  wire logic        run,
  input  wire logic        subcode_sync_out,
  input  wire logic        subcode_data_out,
  output logic             subcode_clk_in,
  output logic [15:0]      data_q,
  output logic [15:0]      sync_q,
  output logic [4:0]       falls_q
);
  // Samples at the fall, before the device moves to the next bit
  initial begin
    subcode_clk_in = 1'b1;
    {data_q, sync_q} = 32'h0000_0000;
    falls_q = 5'h00;
    #7;
    forever begin
      if (run) begin
        subcode_clk_in = 1'b0;
        data_q = {data_q[14:0], subcode_data_out};
        sync_q = {sync_q[14:0], subcode_sync_out};
        falls_q = falls_q + 5'h01;
        #100;
        subcode_clk_in = 1'b1;
        #100;
      end else begin
        #25;
      end
    end
  end
endmodule

/* File: sim/apc_pins_monitor.sv */
// Checker for the audio pin controller, bound to apc_pins.
// Assumes one pclk domain; mirrors the control word from APB writes.
`timescale 1ns/10ps
`include "apc_consts.vh"
module apc_pins_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        bit_clock_port1_oe_n,
  input wire logic        bit_clock_port2_oe_n,
  input wire logic        bit_clock_port3_oe_n,
  input wire logic        word_clock_port1_oe_n,
  input wire logic        word_clock_port2_oe_n,
  input wire logic        word_clock_port3_oe_n,
  input wire logic        serial_in_port1,
  input wire logic        serial_in_port3,
  input wire logic        cd_error_flag_in,
  input wire logic        cd_control_flag_in,
  input wire logic        spdif_in_a,
  input wire logic        spdif_in_b,
  input wire logic        spdif_in_c,
  input wire logic        spdif_in_d,
  input wire logic        serial_out_port1_oe_n,
  input wire logic        serial_out_port2_oe_n,
  input wire logic        spdif_out_consumer_oe_n,
  input wire logic        spdif_out_professional_oe_n,
  input wire logic        subcode_clk_in,
  input wire logic        subcode_sync_out,
  input wire logic        subcode_data_out,
  input wire logic        rx_data_port1,
  input wire logic        rx_data_port3,
  input wire logic        rx_error_flag_port1,
  input wire logic        rx_control_flag_port1,
  input wire logic        spdif_rx_data
);
  logic [15:0] ctrl_q;
  logic [3:0]  since_q;
  logic [6:0]  hi_q;
  logic        rck_q;
  wire  [3:0]  sp = {spdif_in_d, spdif_in_c, spdif_in_b, spdif_in_a};
  wire  [3:0]  rxp = {serial_in_port1, serial_in_port3, cd_error_flag_in,
    cd_control_flag_in};

  // Saturates so a data change far from any clock fall still fails
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= 16'h0000;
      since_q <= 4'hf;
      hi_q    <= 7'h00;
      rck_q   <= 1'b1;
    end else begin
      if (psel && penable && pwrite && paddr == `APC_REG_CTRL)
        ctrl_q <= pwdata[15:0];
      rck_q   <= subcode_clk_in;
      if (rck_q && !subcode_clk_in)
        since_q <= 4'h0;
      else if (since_q != 4'hf)
        since_q <= since_q + 4'h1;
      hi_q    <= subcode_sync_out ? hi_q + 7'h01 : 7'h00;
    end
  end

  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_clk_pins_rst: assert property (
    $rose(presetn) |-> &{bit_clock_port1_oe_n, bit_clock_port2_oe_n,
      bit_clock_port3_oe_n, word_clock_port1_oe_n, word_clock_port2_oe_n,
      word_clock_port3_oe_n})
    else $error("clock pin driven after reset");
  a_out_pins_rst: assert property (
    $rose(presetn) |-> !(serial_out_port1_oe_n | serial_out_port2_oe_n |
      spdif_out_consumer_oe_n | spdif_out_professional_oe_n))
    else $error("audio output not driven after reset");
  a_dir_out: assert property (
    (ctrl_q[0] && ctrl_q[3] && !ctrl_q[9])[*3]
      |-> !bit_clock_port1_oe_n && !word_clock_port1_oe_n)
    else $error("port 1 clocks not driven");
  a_mclk_in: assert property (
    ctrl_q[6][*3] |-> word_clock_port3_oe_n)
    else $error("master clock pin driven");
  a_rx_follow: assert property (
    (!ctrl_q[12] && $stable(rxp))[*8] |-> {rx_data_port1, rx_data_port3,
      rx_error_flag_port1, rx_control_flag_port1} == rxp)
    else $error("received levels differ from pins");
  a_spdif_sel: assert property (
    ($stable(sp[ctrl_q[8:7]]) && $stable(ctrl_q[8:7]))[*8]
      |-> spdif_rx_data == sp[ctrl_q[8:7]])
    else $error("receiver not fed by selected pin");
  a_sync_len: assert property (
    $fell(subcode_sync_out) |-> hi_q inside {[62:66]})
    else $error("sync not held for one byte");
  a_sub_timing: assert property (
    $changed(subcode_data_out) |-> since_q inside {[3:7]})
    else $error("subcode data moved away from clock fall");
endmodule

bind apc_pins apc_pins_monitor i_apc_pins_monitor (.*);

/* File: sim/tb_apc_pins.sv */
// Bench for the audio pin controller: APB tasks, pin drivers, encoder.
// Assumes the checker binds itself; DIV reset ticks every 4 pclk.
`timescale 1ns/10ps
`include "apc_consts.vh"
module tb_apc_pins;
  logic        pclk, presetn, psel, penable, pwrite, run, e, pb;
  logic [3:0]  v, sp;
  logic [5:0]  cp;
  logic [7:0]  paddr;
  logic [31:0] pwdata, q;
  int          errors, tests_run, n;
  wire  [31:0] prdata;
  wire  [15:0] enc_data, enc_sync;
  wire  [4:0]  enc_falls;
  wire  [2:0]  port_bit_clk, port_word_clk;
  wire         pready, pslverr, subcode_clk_in, subcode_sync_out;
  wire         subcode_sync_out_oe_n, subcode_data_out, subcode_data_out_oe_n;
  wire         bit_clock_port1_o, bit_clock_port2_o, bit_clock_port3_o;
  wire         bit_clock_port1_oe_n, bit_clock_port2_oe_n;
  wire         bit_clock_port3_oe_n, word_clock_port1_oe_n;
  wire         word_clock_port2_oe_n, word_clock_port3_oe_n;
  wire         word_clock_port1_o, word_clock_port2_o, word_clock_port3_o;
  wire         serial_out_port1, serial_out_port1_oe_n, serial_out_port2;
  wire         serial_out_port2_oe_n, spdif_out_consumer;
  wire         spdif_out_consumer_oe_n, spdif_out_professional;
  wire         spdif_out_professional_oe_n, rx_data_port1, rx_data_port3;
  wire         rx_error_flag_port1, rx_control_flag_port1, spdif_rx_data;
  // Pin level: the device wins while its enable is low
  wire bit_clock_port1_i  = bit_clock_port1_oe_n ? cp[0] : bit_clock_port1_o;
  wire bit_clock_port2_i  = bit_clock_port2_oe_n ? cp[1] : bit_clock_port2_o;
  wire bit_clock_port3_i  = bit_clock_port3_oe_n ? cp[2] : bit_clock_port3_o;
  wire word_clock_port1_i = word_clock_port1_oe_n ? cp[3] : word_clock_port1_o;
  wire word_clock_port2_i = word_clock_port2_oe_n ? cp[4] : word_clock_port2_o;
  wire word_clock_port3_i = word_clock_port3_oe_n ? cp[5] : word_clock_port3_o;
  wire serial_in_port1 = v[3], serial_in_port3 = v[2];
  wire cd_error_flag_in = v[1], cd_control_flag_in = v[0];
  wire tx_data_port1 = v[3], tx_data_port2 = v[2];
  wire tx_spdif_consumer = v[1], tx_spdif_professional = v[0];
  wire spdif_in_a = sp[0], spdif_in_b = sp[1];
  wire spdif_in_c = sp[2], spdif_in_d = sp[3];

  apc_pins i_apc_pins (.*);
  apc_encoder_model i_apc_encoder_model (.run(run),
    .subcode_sync_out(subcode_sync_out), .subcode_data_out(subcode_data_out),
    .subcode_clk_in(subcode_clk_in), .data_q(enc_data), .sync_q(enc_sync),
    .falls_q(enc_falls));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic close_out();
    $display("Checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, got);
    tests_run++;
    if (got !== ex) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      chk("apb ready", 32'h1, 32'h0);
      close_out();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded so a stuck encoder clock cannot hang the run
  task automatic wait_falls(input int f);
    n = 0;
    while (enc_falls < f && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 1000) begin
      chk("encoder falls", f, enc_falls);
      close_out();
    end
  endtask

  initial begin
    {psel, penable, pwrite, run, presetn} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    cp = 6'h00;
    v = 4'h0;
    sp = 4'h0;
    errors = 0;
    tests_run = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `APC_REG_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, q);
    apb(1'b0, `APC_REG_DIV, 32'h0);
    chk("div reset", 32'h3, q);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped read", 32'h1, {q[30:0], e});
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, `APC_REG_CTRL, {23'h0, s[1:0], 7'h00});
      sp <= 4'h1 << s;
      cyc(10);
      chk("receiver on", 32'h1, spdif_rx_data);
      apb(1'b0, `APC_REG_GPIO_IN, 32'h0);
      chk("gpio in spdif", 4'h1 << s, q[13:10]);
      sp <= ~(4'h1 << s);
      cyc(10);
      chk("receiver off", 32'h0, spdif_rx_data);
    end
    $display("test receiver select done");
    apb(1'b1, `APC_REG_CTRL, 32'h0);
    for (int i = 0; i < 2; i++) begin
      v <= i ? 4'h5 : 4'ha;
      cp <= i ? 6'h15 : 6'h2a;
      cyc(10);
      chk("rx pins", v, {rx_data_port1, rx_data_port3,
        rx_error_flag_port1, rx_control_flag_port1});
      chk("port clocks", cp, {port_word_clk, port_bit_clk});
      chk("tx pins", v, {serial_out_port1, serial_out_port2,
        spdif_out_consumer, spdif_out_professional});
      apb(1'b0, `APC_REG_GPIO_IN, 32'h0);
      chk("gpio in", {v[0], v[1], v[2], v[3], cp}, q[9:0]);
    end
    $display("test pin inputs done");
    apb(1'b1, `APC_REG_CTRL, 32'h3f);
    cyc(4);
    chk("clock enables", 32'h0, {bit_clock_port1_oe_n, bit_clock_port2_oe_n,
      bit_clock_port3_oe_n, word_clock_port1_oe_n, word_clock_port2_oe_n,
      word_clock_port3_oe_n});
    n = 0;
    pb = bit_clock_port1_o;
    repeat (80) begin
      @(negedge pclk);
      if (bit_clock_port1_o !== pb)
        n++;
      pb = bit_clock_port1_o;
    end
    chk("bit clock toggles", 32'h14, n);
    apb(1'b1, `APC_REG_CTRL, 32'h60);
    cyc(4);
    chk("master clock pin", 32'h1, word_clock_port3_oe_n);
    apb(1'b1, `APC_REG_GPIO_EN, 32'h1);
    apb(1'b1, `APC_REG_GPIO_OUT, 32'h1);
    apb(1'b1, `APC_REG_CTRL, 32'h1200);
    cyc(10);
    chk("gpio drive", 32'h1, {bit_clock_port1_oe_n, bit_clock_port1_o});
    chk("rx in gpio mode", 32'h0, {rx_data_port1, rx_data_port3,
      rx_error_flag_port1, rx_control_flag_port1});
    $display("test directions done");
    apb(1'b1, `APC_REG_CTRL, 32'h0);
    apb(1'b1, `APC_REG_SUBCODE, 32'h1a5);
    apb(1'b0, `APC_REG_STATUS, 32'h0);
    chk("subcode pending", 32'h9, q);
    run <= 1'b1;
    wait_falls(2);
    apb(1'b1, `APC_REG_SUBCODE, 32'h03c);
    wait_falls(17);
    run <= 1'b0;
    cyc(20);
    chk("subcode data", 32'ha53c, enc_data);
    chk("subcode sync", 32'hff00, enc_sync);
    chk("subcode idle", 32'h0, {subcode_sync_out, subcode_data_out});
    $display("test subcode done");
    close_out();
  end
endmodule
